// file: verilog/ptq_pkg.sv
package ptq_pkg;
  // register byte offsets within one port's space
  localparam logic [11:0] OFS_GATE_CTL   = 12'h920;
  localparam logic [11:0] OFS_EV_INDEX   = 12'h923;
  localparam logic [11:0] OFS_EV_BYTE3   = 12'h924; // bits 31:24
  localparam logic [11:0] OFS_EV_BYTE2   = 12'h925;
  localparam logic [11:0] OFS_EV_BYTE1   = 12'h926;
  localparam logic [11:0] OFS_EV_BYTE0   = 12'h927; // bits 7:0
  localparam logic [11:0] OFS_DROP_BYTE0 = 12'hA03; // drop mode byte
  localparam logic [11:0] OFS_DROP_BYTE3 = 12'hA00;
  localparam logic [11:0] OFS_MASK_BYTE0 = 12'hA07; // membership byte
  localparam logic [11:0] OFS_MASK_BYTE3 = 12'hA04;

  // shaper gate control fields
  localparam int CTL_CUT_THRU_BIT   = 7;
  localparam int CTL_RESTRICT_BIT   = 6;
  localparam logic [7:0] CTL_WMASK  = 8'hC3;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] IDX_WMASK  = 8'h7F;
  localparam logic [6:0] IDX_RESET  = 7'h00;
  localparam logic [1:0] DROP_RESET = 2'h0;
  localparam logic [6:0] MASK_RESET = 7'h7F;
  localparam logic [31:0] EV_RESET  = 32'h00000000;

  // reference time selection
  localparam logic [1:0] REF_NONE     = 2'h0;
  localparam logic [1:0] REF_FREE_RUN = 2'h1;
  localparam logic [1:0] REF_PPS      = 2'h2;
  localparam logic [1:0] REF_CROSSED  = 2'h3;

  // schedule entry layout and event codes
  localparam int EV_CODE_MSB = 31;
  localparam int EV_CODE_LSB = 29;
  localparam int EV_TIME_W   = 29;
  localparam logic [2:0] EV_CLOSE  = 3'h0;
  localparam logic [2:0] EV_GUARD  = 3'h1;
  localparam logic [2:0] EV_OPEN   = 3'h2;
  localparam logic [2:0] EV_REPEAT = 3'h7;

  // queue shaper mode encodings
  localparam logic [1:0] SHAPE_NONE   = 2'h0;
  localparam logic [1:0] SHAPE_CREDIT = 2'h1;
  localparam logic [1:0] SHAPE_TIMED  = 2'h2;

  // drop modes
  localparam logic [1:0] DROP_NONE = 2'h0;

  // internal one-second pulse
  localparam longint ONE_SEC_NS   = 1000000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam int     ONE_SEC_CYCLES = int'(ONE_SEC_NS / CLK_PERIOD_NS);

  typedef enum logic [0:0] {WALK_IDLE, WALK_RUN} ptq_walk_t;
endpackage : ptq_pkg

// file: verilog/ptq_gate_walker.sv
`timescale 1ns/1ps
// walks the schedule list from a cycle start and drives the gate state
module ptq_gate_walker
  import ptq_pkg::*;
#(
  parameter int IDX_W = 7
) (
  input  wire logic             mclk,        // system clock
  input  wire logic             reset,       // synchronous, active high
  input  wire logic             cycle_start, // restart pulse
  input  wire logic             enable,      // a reference source is selected
  input  wire logic [31:0]      entry_data,  // entry at entry_idx
  output logic      [IDX_W-1:0] entry_idx,   // entry being waited on
  output logic                  gate_open,   // open window in force
  output logic                  guard_band   // guard band in force
);
  ptq_walk_t                state;
  ptq_walk_t                next_state;
  logic [EV_TIME_W-1:0]     cycle_cnt;
  logic [IDX_W-1:0]         next_idx;

  // decode of the current entry
  wire  [2:0]           ev_code  = entry_data[EV_CODE_MSB:EV_CODE_LSB];        // RULE_08
  wire  [EV_TIME_W-1:0] ev_time  = entry_data[EV_TIME_W-1:0];                  // RULE_10
  wire                  ev_due   = (state == WALK_RUN) && (cycle_cnt >= ev_time);
  wire                  ev_rpt   = ev_due && (ev_code == EV_REPEAT);            // RULE_09
  wire                  last_idx = (entry_idx == {IDX_W{1'b1}});

  // index advances in order; repeat goes back to the first entry
  assign next_idx = ev_rpt ? '0 : entry_idx + IDX_W'(1);                        // RULE_19
  always_comb begin
    next_state = state;
    if (!enable)
      next_state = WALK_IDLE;
    else if (cycle_start)
      next_state = WALK_RUN;
    else if (ev_due && !ev_rpt && last_idx)
      next_state = WALK_IDLE; // list exhausted, wait for next start
  end

  // times count from the cycle start, so entries hold absolute offsets
  always_ff @(posedge mclk) begin
    if (reset) begin
      state      <= WALK_IDLE;
      cycle_cnt  <= '0;
      entry_idx  <= '0;
      gate_open  <= 1'b0;
      guard_band <= 1'b0;
    end else begin
      state <= next_state;
      if (!enable || cycle_start) begin
        cycle_cnt  <= '0;
        entry_idx  <= '0;
        gate_open  <= 1'b0;
        guard_band <= 1'b0;
      end else if (state == WALK_RUN) begin
        cycle_cnt <= ev_rpt ? '0 : cycle_cnt + EV_TIME_W'(1);                   // RULE_19
        if (ev_due) begin
          entry_idx <= next_idx;                                                 // RULE_19
          unique case (ev_code)
            EV_OPEN: begin
              gate_open  <= 1'b1;                                                // RULE_08
              guard_band <= 1'b0;
            end
            EV_CLOSE: begin
              gate_open  <= 1'b0;                                                // RULE_08
              guard_band <= 1'b0;
            end
            EV_GUARD: begin
              gate_open  <= 1'b0;                                                // RULE_09
              guard_band <= 1'b1;
            end
            default: ; // repeat and reserved codes leave the gate as is
          endcase
        end
      end
    end
  end
endmodule : ptq_gate_walker

// file: verilog/ptq_port_ctrl.sv
`timescale 1ns/1ps
// Operation
// RULE_01: cut-through bit set lets shaped traffic cut through; clear disables it.
// RULE_02: restricted bit holds shaped packets until the open window begins.
// RULE_03: held packets stay queued, store-and-forward or cut-through alike, never discarded.
// RULE_04: restricted bit clear lets shaped packets go anytime; reset state.
// RULE_05: reference 11 starts cycle when reference time crossed; 00 uses none.
// RULE_06: reference 10 restarts the cycle on each pulse-per-second.
// RULE_07: reference 01 free-runs, restarting on an internal one-second pulse.
// RULE_08: entry bits 31:29 hold the event code; 010 opens, 000 closes.
// RULE_09: code 001 starts guard band, 111 repeats; 011 to 110 reserved.
// RULE_10: entry bits 28:0 hold the event time in system clock cycles.
// RULE_11: drop mode 00 drops nothing and raises flow control while congested.
// RULE_12: while congested, modes 01/10/11 drop priorities up to 0/1/2.
// RULE_13: any nonzero drop mode stops flow control toward this port.
// RULE_14: membership mask is seven bits, bit 0 for port 1, resets to ones.
// RULE_15: membership bit 1 allows forwarding to that port, 0 blocks it.
// RULE_16: membership filtering ignores VLAN tags and the VLAN table.
// RULE_17: the schedule governs a queue only when its shaper mode is 10.
// RULE_18: the seven-bit event index selects which entry the event register reaches.
// RULE_19: entries run in index order from cycle start; repeat restarts the list.
module ptq_port_ctrl
  import ptq_pkg::*;
#(
  parameter int NUM_QUEUES   = 4,
  parameter int NUM_PORTS    = 7,
  parameter int EVENT_DEPTH  = 128,
  parameter int SEC_CYCLES   = ONE_SEC_CYCLES
) (
  input  wire logic                    mclk,          // system clock, 25 MHz
  input  wire logic                    reset,         // synchronous, active high
  input  wire logic [11:0]             reg_addr,      // byte offset in port space
  input  wire logic                    reg_wr,        // byte write strobe
  input  wire logic                    reg_rd,        // byte read strobe
  input  wire logic [7:0]              reg_wdata,     // write byte
  output logic      [7:0]              reg_rdata,     // read byte, one cycle later
  input  wire logic                    pps_pulse,     // pulse per second from time logic
  input  wire logic                    ref_crossed,   // reference time crossed pulse
  input  wire logic [2*NUM_QUEUES-1:0] queue_shaper,  // per-queue shaper mode
  output logic      [NUM_QUEUES-1:0]   queue_tx_ok,   // per-queue transmit permission
  output logic                         cut_through_ok,// shaped traffic may cut through
  output logic                         gate_open,     // schedule open window
  output logic                         guard_band,    // schedule guard band
  input  wire logic                    dest_congested,// a destination is congested
  input  wire logic                    pkt_valid,     // ingress packet decision request
  input  wire logic [1:0]              pkt_prio,      // its priority
  output logic                         pkt_drop,      // drop that packet
  output logic                         flow_ctrl,     // assert flow control to port
  input  wire logic [NUM_PORTS-1:0]    fwd_req,       // lookup destination ports
  output logic      [NUM_PORTS-1:0]    fwd_allowed    // destinations after membership
);
  localparam int IDX_W = $clog2(EVENT_DEPTH);
  localparam int SEC_W = $clog2(SEC_CYCLES);

  logic [7:0]             gate_ctl;
  logic [IDX_W-1:0]       ev_index;
  logic [31:0]            ev_mem [EVENT_DEPTH];
  logic [1:0]             drop_mode;
  logic [NUM_PORTS-1:0]   member_mask;
  logic [SEC_W-1:0]       sec_cnt;
  logic                   sec_pulse;
  logic [IDX_W-1:0]       walk_idx;
  logic                   walk_open;
  logic                   walk_guard;
  logic [7:0]             next_rdata;

  // register decode
  wire        sel_ctl   = (reg_addr == OFS_GATE_CTL);
  wire        sel_idx   = (reg_addr == OFS_EV_INDEX);
  wire        sel_ev    = (reg_addr >= OFS_EV_BYTE3) && (reg_addr <= OFS_EV_BYTE0);
  wire        sel_drop  = (reg_addr >= OFS_DROP_BYTE3) && (reg_addr <= OFS_DROP_BYTE0);
  wire        sel_mask  = (reg_addr >= OFS_MASK_BYTE3) && (reg_addr <= OFS_MASK_BYTE0);
  wire [1:0]  ev_lane   = 2'(OFS_EV_BYTE0 - reg_addr); // 0 selects bits 7:0
  wire [31:0] ev_cur    = ev_mem[ev_index];                                      // RULE_18
  wire [1:0]  ref_sel   = gate_ctl[1:0];
  wire        restrict_on = gate_ctl[CTL_RESTRICT_BIT];

  // control, index, drop mode and membership registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      gate_ctl    <= CTL_RESET;                                                  // RULE_04
      ev_index    <= IDX_RESET[IDX_W-1:0];
      drop_mode   <= DROP_RESET;
      member_mask <= MASK_RESET[NUM_PORTS-1:0];                                  // RULE_14
    end else if (reg_wr) begin
      if (sel_ctl)
        gate_ctl <= reg_wdata & CTL_WMASK; // reserved bits stay zero
      if (sel_idx)
        ev_index <= reg_wdata[IDX_W-1:0];                                        // RULE_18
      if (reg_addr == OFS_DROP_BYTE0)
        drop_mode <= reg_wdata[1:0];
      if (reg_addr == OFS_MASK_BYTE0)
        member_mask <= reg_wdata[NUM_PORTS-1:0];                                 // RULE_14
    end
  end

  // schedule list in flip-flops, one byte lane per access
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < EVENT_DEPTH; i++)
        ev_mem[i] <= EV_RESET;
    end else if (reg_wr && sel_ev) begin
      ev_mem[ev_index][8*ev_lane +: 8] <= reg_wdata;                             // RULE_18
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (sel_ctl)
      next_rdata = gate_ctl;
    else if (sel_idx)
      next_rdata = 8'(ev_index) & IDX_WMASK;
    else if (sel_ev)
      next_rdata = ev_cur[8*ev_lane +: 8];
    else if (reg_addr == OFS_DROP_BYTE0)
      next_rdata = {6'h00, drop_mode};
    else if (reg_addr == OFS_MASK_BYTE0)
      next_rdata = 8'(member_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // internal one-second pulse, counted only while free-running
  always_ff @(posedge mclk) begin
    if (reset || ref_sel != REF_FREE_RUN) begin
      sec_cnt   <= '0;
      sec_pulse <= 1'b0;
    end else if (sec_cnt == SEC_W'(SEC_CYCLES - 1)) begin
      sec_cnt   <= '0;
      sec_pulse <= 1'b1;                                                         // RULE_07
    end else begin
      sec_cnt   <= sec_cnt + SEC_W'(1);
      sec_pulse <= 1'b0;
    end
  end

  // cycle start source; selection 00 leaves the schedule idle
  wire walk_en     = (ref_sel != REF_NONE);                                      // RULE_05
  wire cycle_start = ((ref_sel == REF_CROSSED)  && ref_crossed) ||               // RULE_05
                     ((ref_sel == REF_PPS)      && pps_pulse)   ||               // RULE_06
                     ((ref_sel == REF_FREE_RUN) && sec_pulse);                   // RULE_07

  ptq_gate_walker #(
    .IDX_W (IDX_W)
  ) u_walker (
    .mclk        (mclk),
    .reset       (reset),
    .cycle_start (cycle_start),
    .enable      (walk_en),
    .entry_data  (ev_mem[walk_idx]),
    .entry_idx   (walk_idx),
    .gate_open   (walk_open),
    .guard_band  (walk_guard)
  );

  // per-queue permission; held queues are only stalled, nothing is discarded
  logic [NUM_QUEUES-1:0] next_tx_ok;
  always_comb begin
    next_tx_ok = '1;
    for (int q = 0; q < NUM_QUEUES; q++) begin
      if (queue_shaper[2*q +: 2] == SHAPE_TIMED && restrict_on)                  // RULE_17
        next_tx_ok[q] = walk_open;                                               // RULE_02 RULE_03
      // timed queue without restriction may send at any time
    end                                                                          // RULE_04
  end

  // drop decision: mode n drops priorities below n while congested
  wire drop_hit = dest_congested && (drop_mode != DROP_NONE) &&
                  (pkt_prio < drop_mode);                                        // RULE_12

  // outputs registered for clean timing toward the queue manager
  always_ff @(posedge mclk) begin
    if (reset) begin
      queue_tx_ok    <= '1;
      cut_through_ok <= 1'b0;
      gate_open      <= 1'b0;
      guard_band     <= 1'b0;
      pkt_drop       <= 1'b0;
      flow_ctrl      <= 1'b0;
      fwd_allowed    <= '0;
    end else begin
      queue_tx_ok    <= next_tx_ok;
      cut_through_ok <= gate_ctl[CTL_CUT_THRU_BIT];                              // RULE_01
      gate_open      <= walk_open;
      guard_band     <= walk_guard;
      pkt_drop       <= pkt_valid && drop_hit;                                   // RULE_12
      flow_ctrl      <= dest_congested && (drop_mode == DROP_NONE);              // RULE_11 RULE_13
      fwd_allowed    <= fwd_req & member_mask;                                   // RULE_15 RULE_16
    end
  end
endmodule : ptq_port_ctrl

// file: bench/ptq_chk.sv
`timescale 1ns/1ps
// pin-level checks on the port control block
module ptq_chk
  import ptq_pkg::*;
#(
  parameter int NUM_QUEUES = 4,
  parameter int NUM_PORTS  = 7
) (
  input wire logic                  mclk,           // clock
  input wire logic                  reset,          // sync reset
  input wire logic [11:0]           reg_addr,       // offset
  input wire logic                  reg_wr,         // write
  input wire logic                  reg_rd,         // read
  input wire logic [7:0]            reg_wdata,      // write byte
  input wire logic [7:0]            reg_rdata,      // read byte
  input wire logic [NUM_QUEUES-1:0] queue_tx_ok,    // permits
  input wire logic                  cut_through_ok, // cut-through
  input wire logic                  gate_open,      // window
  input wire logic                  guard_band,     // guard
  input wire logic                  dest_congested, // congestion
  input wire logic                  pkt_valid,      // decision request
  input wire logic [1:0]            pkt_prio,       // priority
  input wire logic                  pkt_drop,       // drop
  input wire logic                  flow_ctrl,      // flow control
  input wire logic [NUM_PORTS-1:0]  fwd_req,        // wanted ports
  input wire logic [NUM_PORTS-1:0]  fwd_allowed     // granted ports
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // offsets inside a register's byte range; the rest must read zero
  wire logic mapped = (reg_addr == OFS_GATE_CTL) || (reg_addr == OFS_EV_INDEX) ||
                      (reg_addr[11:2] == 10'h249) || (reg_addr[11:3] == 9'h140);

  a_cut_thru_bit: assert property (reg_wr && reg_addr == OFS_GATE_CTL |->
    ##2 cut_through_ok == $past(reg_wdata[7], 2)) else $error("cut-through level wrong");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  a_flow_cause: assert property (flow_ctrl |-> $past(dest_congested))
    else $error("flow control without congestion");
  a_drop_cause: assert property (pkt_drop |->
    $past(pkt_valid && dest_congested && pkt_prio != 2'h3)) else $error("drop without cause");
  a_drop_no_flow: assert property (pkt_drop |-> !flow_ctrl)
    else $error("flow control while dropping");
  a_fwd_subset: assert property ((fwd_allowed & ~$past(fwd_req)) == '0)
    else $error("forwarded to a port not asked for");
  a_guard_closed: assert property (guard_band |-> !gate_open)
    else $error("gate open in guard band");
  a_reset_state: assert property ($past(reset) |-> &queue_tx_ok && !gate_open &&
    !cut_through_ok && fwd_allowed == '0) else $error("bad state after reset");
endmodule : ptq_chk

bind ptq_port_ctrl ptq_chk #(.NUM_QUEUES(NUM_QUEUES), .NUM_PORTS(NUM_PORTS)) u_ptq_chk (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .queue_tx_ok(queue_tx_ok),
  .cut_through_ok(cut_through_ok), .gate_open(gate_open), .guard_band(guard_band),
  .dest_congested(dest_congested), .pkt_valid(pkt_valid), .pkt_prio(pkt_prio),
  .pkt_drop(pkt_drop), .flow_ctrl(flow_ctrl), .fwd_req(fwd_req), .fwd_allowed(fwd_allowed));

// file: bench/ptq_port_ctrl_test.sv
`timescale 1ns/1ps
// self-checking bench for the port control block
module ptq_port_ctrl_test;
  import ptq_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, g_chk = 1'b0;
  logic pps_pulse = 1'b0, ref_crossed = 1'b0, dest_congested = 1'b0, pkt_valid = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, queue_shaper = 8'h26; // q0,q2 timed, q1 credit, q3 none
  logic [1:0] pkt_prio = 2'h0;
  logic [6:0] fwd_req = 7'h00, fwd_allowed;
  logic [7:0] reg_rdata, mask;
  logic [3:0] queue_tx_ok;
  logic cut_through_ok, gate_open, guard_band, pkt_drop, flow_ctrl, rd_q, dv_q, gv_q;
  logic [31:0] rnd;
  logic [7:0] q_reg[$];
  logic [8:0] q_dec[$];
  logic [6:0] q_gate[$];
  int error_cnt = 0, n_tests = 0;
  logic [11:0] ra[8] = '{OFS_GATE_CTL, OFS_EV_INDEX, OFS_EV_BYTE3, OFS_EV_BYTE0,
                         OFS_DROP_BYTE3, OFS_DROP_BYTE0, OFS_MASK_BYTE0, 12'h921};
  logic [7:0] re[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};

  always #20 mclk = ~mclk;

  // short second: keeps the free-running restart inside the run
  ptq_port_ctrl #(.SEC_CYCLES(20)) u_ptq_port_ctrl (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pps_pulse(pps_pulse),
    .ref_crossed(ref_crossed), .queue_shaper(queue_shaper), .queue_tx_ok(queue_tx_ok),
    .cut_through_ok(cut_through_ok), .gate_open(gate_open), .guard_band(guard_band),
    .dest_congested(dest_congested), .pkt_valid(pkt_valid), .pkt_prio(pkt_prio),
    .pkt_drop(pkt_drop), .flow_ctrl(flow_ctrl), .fwd_req(fwd_req), .fwd_allowed(fwd_allowed));

  task automatic tally(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : tally
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    tally({1'b0, g}, {1'b0, e});
  endtask : cmp_reg
  task automatic cmp_dec(input logic [8:0] g, input logic [8:0] e);
    tally(g, e);
  endtask : cmp_dec
  task automatic cmp_gate(input logic [6:0] g, input logic [6:0] e);
    tally({2'h0, g}, {2'h0, e});
  endtask : cmp_gate

  // results are judged on the falling edge after the edge that made them
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    dv_q <= pkt_valid;
    gv_q <= g_chk;
  end
  always @(negedge mclk) begin
    if (rd_q) cmp_reg(reg_rdata, q_reg.pop_front());
    if (dv_q) cmp_dec({pkt_drop, flow_ctrl, fwd_allowed}, q_dec.pop_front());
    if (gv_q) cmp_gate({cut_through_ok, guard_band, gate_open, queue_tx_ok},
                       q_gate.pop_front());
  end

  // one idle cycle between accesses so a strobe never flips twice at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk) reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    q_reg.push_back(e);
    @(negedge mclk) reg_rd = 1'b0;
  endtask : rd
  task automatic ent(input logic [6:0] i, input logic [2:0] c, input logic [28:0] t);
    wr(OFS_EV_INDEX, {1'b0, i});
    wr(OFS_EV_BYTE3, {c, t[28:24]});
    wr(OFS_EV_BYTE2, t[23:16]);
    wr(OFS_EV_BYTE1, t[15:8]);
    wr(OFS_EV_BYTE0, t[7:0]);
  endtask : ent
  task automatic dec(input logic [1:0] m, input logic [1:0] p);
    @(negedge mclk);
    rnd = $urandom();
    pkt_valid = 1'b1;
    pkt_prio = p;
    dest_congested = rnd[0];
    fwd_req = rnd[14:8];
    q_dec.push_back({rnd[0] && p < m, rnd[0] && m == DROP_NONE, rnd[14:8] & mask[6:0]});
    @(negedge mclk) pkt_valid = 1'b0;
  endtask : dec
  // open at 2, close at 6, guard at 8, repeat at 12; outputs trail by 2
  // the guard band outlives the repeat until the next open event
  task automatic sched(input logic [7:0] ctl);
    wr(OFS_GATE_CTL, 8'h40); // ref 00 idles the walker and shuts the gate
    wr(OFS_GATE_CTL, ctl);
    for (int k = 0; k < 14; k++) begin
      @(negedge mclk);
      ref_crossed = (k == 0) && (ctl[1:0] == REF_CROSSED);
      pps_pulse = (k == 0) && (ctl[1:0] == REF_PPS);
      g_chk = 1'b1;
      q_gate.push_back({ctl[7], k > 9, k inside {[4:7]}, 1'b1,
                        !ctl[6] || k inside {[4:7]}, 1'b1,
                        !ctl[6] || k inside {[4:7]}});
    end
    @(negedge mclk) g_chk = 1'b0;
  endtask : sched

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    #(40 * 4000);
    error_cnt++;
    end_of_test;
  end

  initial begin
    rnd = $urandom(85402);
    mask = 8'h7F;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    foreach (ra[i]) rd(ra[i], re[i]);
    $display("reset values done");
    wr(OFS_GATE_CTL, 8'hFF);
    rd(OFS_GATE_CTL, CTL_WMASK);
    wr(OFS_EV_INDEX, 8'hFF);
    rd(OFS_EV_INDEX, IDX_WMASK);
    wr(OFS_DROP_BYTE3, 8'hFF);
    rd(OFS_DROP_BYTE3, 8'h00);
    ent(7'h00, EV_OPEN, 29'h2);
    ent(7'h01, EV_CLOSE, 29'h6);
    ent(7'h02, EV_GUARD, 29'h8);
    ent(7'h03, EV_REPEAT, 29'hC);
    rd(OFS_EV_BYTE3, {EV_REPEAT, 5'h00});
    wr(OFS_EV_INDEX, 8'h02);
    rd(OFS_EV_BYTE0, 8'h08);
    $display("register access done");
    sched(8'h43);
    sched(8'h82);
    wr(OFS_GATE_CTL, 8'h40);
    wr(OFS_GATE_CTL, 8'h41);
    for (int k = 0; k < 40 && gate_open !== 1'b1; k++) @(negedge mclk);
    g_chk = 1'b1;
    q_gate.push_back(7'h1F);
    @(negedge mclk) g_chk = 1'b0;
    $display("schedule done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_DROP_BYTE0, 8'hFC | 8'(m));
      rd(OFS_DROP_BYTE0, 8'(m));
      mask = 8'($urandom());
      wr(OFS_MASK_BYTE0, mask);
      rd(OFS_MASK_BYTE0, mask & 8'h7F);
      for (int p = 0; p < 4; p++) dec(2'(m), 2'(p));
    end
    $display("drop and forwarding done");
    end_of_test;
  end
endmodule : ptq_port_ctrl_test
